// [hdl/imager_pkg.sv]
// Shared constants, encodings and pin bundles for the imager control block
package imager_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int PIX_W = 12;
  localparam int GAIN_W = 12;
  localparam int OFS_PIN_W = 8;
  localparam int OFS_W = 10;
  localparam int SEL_W = 3;
  localparam int COLOURS = 3;
  localparam int AGAIN_W = 4;
  localparam int SCALE_W = 3;
  localparam int SUM_W = 14;
  localparam int DIFF_W = 13;
  localparam int PROD_W = 27;
  localparam int MUL_SHIFT = 14;

  // ---------------------------------------------------------------
  // Register selects
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] ADDR_CONFIG = 3'h0;
  localparam logic [SEL_W-1:0] ADDR_CONFIG_TWO = 3'h1;
  localparam logic [SEL_W-1:0] ADDR_ANALOG_GAIN = 3'h2;
  localparam logic [SEL_W-1:0] ADDR_ODD_OFS = 3'h3;
  localparam logic [SEL_W-1:0] ADDR_EVEN_OFS = 3'h4;
  localparam logic [SEL_W-1:0] ADDR_INPUT_OFS = 3'h5;
  localparam logic [SEL_W-1:0] ADDR_RESERVED = 3'h6;
  localparam logic [SEL_W-1:0] ADDR_TWO_CHANNEL = 3'h7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_SCALE_LSB = 0;
  localparam int CFG_DIST_A = 3;
  localparam int CFG_DIST_B = 4;
  localparam int CFG_DIST_C = 5;
  localparam int CFG_PTR_LSB = 6;
  localparam int CFG2_SAMPLER = 0;
  localparam int CFG2_MONO = 1;
  localparam int CFG2_SPAN_4V = 2;
  localparam int CFG2_SPAN_2V = 3;
  localparam int CFG2_SPAN_EXT = 4;
  localparam int CFG2_CLAMP_LSB = 6;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [PIX_W-1:0] PIX_MAX = 12'hFFF;
  localparam logic [PIX_W-1:0] PIX_ZERO = 12'h000;
  localparam logic [PIX_W-1:0] PIX_RESET = 12'h000;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    COLOUR_RED = 2'h0,
    COLOUR_GREEN = 2'h1,
    COLOUR_BLUE = 2'h2,
    COLOUR_RSVD = 2'h3
  } colour_t;

  typedef enum logic [1:0] {
    CLAMP_LINE = 2'h0,
    CLAMP_PIXEL = 2'h1,
    CLAMP_NONE = 2'h2,
    CLAMP_RSVD = 2'h3
  } clamp_t;

  // Channel sequencer, Gray coded along red, green, blue
  typedef enum logic [1:0] {
    SEQ_RED = 2'b00,
    SEQ_GREEN = 2'b01,
    SEQ_BLUE = 2'b11
  } seq_t;

  // ---------------------------------------------------------------
  // Pin bundles
  // ---------------------------------------------------------------
  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [SEL_W-1:0] reg_select;
    logic [REG_W-1:0] data;
  } mpu_pins_t;

  typedef struct packed {
    logic converter_clock;
    logic line_start;
    logic first_sample_clock;
    logic [GAIN_W-1:0] gain;
    logic [OFS_PIN_W-1:0] offset;
  } pixel_pins_t;

  localparam int MPU_PINS_W = $bits(mpu_pins_t);
  localparam int PIXEL_PINS_W = $bits(pixel_pins_t);
  localparam mpu_pins_t MPU_IDLE = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
  localparam pixel_pins_t PIXEL_IDLE = '{1'b0, 1'b1, 1'b0, 12'h000, 8'h00};

endpackage

// [hdl/pin_filter.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_filter #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] check_ff;

  // ---------------------------------------------------------------
  // Synchroniser chain
  // ---------------------------------------------------------------
  // The first stage feeds only the second one
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
      check_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      check_ff <= sync_ff;
    end
  end

  // ---------------------------------------------------------------
  // Agreement filter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stable_out <= RESET_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync_ff[i] == check_ff[i]) begin
          stable_out[i] <= check_ff[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// [hdl/imager_ctrl_regs.sv]
// Register port, clamp control and pixel-rate correction path of the imager front end
`timescale 1ns/100ps
`default_nettype none

module imager_ctrl_regs (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic [imager_pkg::SEL_W-1:0] reg_select_in,
  input wire logic [imager_pkg::PIX_W-1:0] data_bus_in,
  output logic [imager_pkg::PIX_W-1:0] data_bus_out,
  output logic data_bus_oe_out,
  input wire logic converter_clock_in,
  input wire logic line_start_in,
  input wire logic first_sample_clock_in,
  input wire logic [imager_pkg::GAIN_W-1:0] gain_bus_in,
  input wire logic [imager_pkg::OFS_PIN_W-1:0] offset_bus_in,
  input wire logic [imager_pkg::PIX_W-1:0] adc_code_in,
  output logic sampler_enable_out,
  output logic mono_mode_out,
  output logic [1:0] mono_channel_out,
  output logic span_4v_out,
  output logic span_2v_out,
  output logic span_ext_out,
  output logic input_clamp_switch_out,
  output logic [1:0] channel_sel_out,
  output logic [imager_pkg::COLOURS*imager_pkg::AGAIN_W-1:0] analog_gain_out,
  output logic [imager_pkg::COLOURS*imager_pkg::REG_W-1:0] input_offset_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  imager_pkg::mpu_pins_t mpu_raw;
  imager_pkg::mpu_pins_t mpu_now;
  imager_pkg::mpu_pins_t mpu_prev_ff;
  imager_pkg::pixel_pins_t pix_raw;
  imager_pkg::pixel_pins_t pix_now;
  logic conv_prev_ff;

  assign mpu_raw = '{chip_select_n_in, write_strobe_n_in, read_strobe_n_in, reg_select_in,
                     data_bus_in[imager_pkg::REG_W-1:0]};
  assign pix_raw = '{converter_clock_in, line_start_in, first_sample_clock_in, gain_bus_in, offset_bus_in};

  pin_filter #(
    .WIDTH(imager_pkg::MPU_PINS_W),
    .RESET_VAL(imager_pkg::MPU_IDLE)
  ) mpu_filter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(mpu_raw),
    .stable_out(mpu_now)
  );

  pin_filter #(
    .WIDTH(imager_pkg::PIXEL_PINS_W),
    .RESET_VAL(imager_pkg::PIXEL_IDLE)
  ) pixel_filter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(pix_raw),
    .stable_out(pix_now)
  );

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mpu_prev_ff <= imager_pkg::MPU_IDLE;
      conv_prev_ff <= 1'b0;
    end else begin
      mpu_prev_ff <= mpu_now;
      conv_prev_ff <= pix_now.converter_clock;
    end
  end

  // ---------------------------------------------------------------
  // Register port strobes
  // ---------------------------------------------------------------
  logic write_active;
  logic read_active;
  logic write_done;
  logic conv_rise;

  assign write_active = !mpu_now.chip_select_n && !mpu_now.write_strobe_n;
  assign read_active = !mpu_now.chip_select_n && !mpu_now.read_strobe_n;
  // Data is taken at the end of the strobe, when the host has had time to settle it
  assign write_done = !mpu_prev_ff.chip_select_n && !mpu_prev_ff.write_strobe_n && mpu_now.write_strobe_n;
  assign conv_rise = pix_now.converter_clock && !conv_prev_ff;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [imager_pkg::REG_W-1:0] config_ff;
  logic [imager_pkg::REG_W-1:0] mode_config_two_ff;
  logic [imager_pkg::REG_W-1:0] two_channel_ff;
  logic [imager_pkg::REG_W-1:0] analog_input_offset_ff [imager_pkg::COLOURS];
  logic [imager_pkg::AGAIN_W-1:0] analog_gain_setting_ff [imager_pkg::COLOURS];
  logic [imager_pkg::REG_W-1:0] odd_pixel_offset_ff [imager_pkg::COLOURS];
  logic [imager_pkg::REG_W-1:0] even_pixel_offset_ff [imager_pkg::COLOURS];
  logic [1:0] mono_channel_ff;
  imager_pkg::colour_t pointer;
  logic [imager_pkg::REG_W-1:0] wdata;
  logic [imager_pkg::SEL_W-1:0] wsel;

  assign pointer = imager_pkg::colour_t'(config_ff[imager_pkg::CFG_PTR_LSB +: 2]);
  assign wdata = mpu_prev_ff.data;
  assign wsel = mpu_prev_ff.reg_select;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      config_ff <= imager_pkg::REG_RESET;
      mode_config_two_ff <= imager_pkg::REG_RESET;
      two_channel_ff <= imager_pkg::REG_RESET;
    end else if (write_done) begin
      if (wsel == imager_pkg::ADDR_CONFIG) begin
        config_ff <= wdata;
      end else if (wsel == imager_pkg::ADDR_CONFIG_TWO) begin
        mode_config_two_ff <= wdata;
      end else if (wsel == imager_pkg::ADDR_TWO_CHANNEL) begin
        two_channel_ff <= wdata;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mono_channel_ff <= imager_pkg::COLOUR_RED;
    end else if (write_done && wsel == imager_pkg::ADDR_CONFIG_TWO && pointer != imager_pkg::COLOUR_RSVD) begin
      mono_channel_ff <= pointer;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int c = 0; c < imager_pkg::COLOURS; c++) begin
        analog_input_offset_ff[c] <= imager_pkg::REG_RESET;
        analog_gain_setting_ff[c] <= imager_pkg::REG_RESET[imager_pkg::AGAIN_W-1:0];
        odd_pixel_offset_ff[c] <= imager_pkg::REG_RESET;
        even_pixel_offset_ff[c] <= imager_pkg::REG_RESET;
      end
    end else if (write_done && pointer != imager_pkg::COLOUR_RSVD) begin
      if (wsel == imager_pkg::ADDR_INPUT_OFS) begin
        analog_input_offset_ff[pointer] <= wdata;
      end else if (wsel == imager_pkg::ADDR_ANALOG_GAIN) begin
        analog_gain_setting_ff[pointer] <= wdata[imager_pkg::AGAIN_W-1:0];
      end else if (wsel == imager_pkg::ADDR_ODD_OFS) begin
        odd_pixel_offset_ff[pointer] <= wdata;
      end else if (wsel == imager_pkg::ADDR_EVEN_OFS) begin
        even_pixel_offset_ff[pointer] <= wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [imager_pkg::REG_W-1:0] rdata;

  always_comb begin
    rdata = imager_pkg::REG_RESET;
    if (mpu_now.reg_select == imager_pkg::ADDR_CONFIG) begin
      rdata = config_ff;
    end else if (mpu_now.reg_select == imager_pkg::ADDR_CONFIG_TWO) begin
      rdata = mode_config_two_ff;
    end else if (mpu_now.reg_select == imager_pkg::ADDR_TWO_CHANNEL) begin
      rdata = two_channel_ff;
    end else if (pointer == imager_pkg::COLOUR_RSVD) begin
      rdata = imager_pkg::REG_RESET;
    end else if (mpu_now.reg_select == imager_pkg::ADDR_ANALOG_GAIN) begin
      rdata = {{(imager_pkg::REG_W-imager_pkg::AGAIN_W){1'b0}}, analog_gain_setting_ff[pointer]};
    end else if (mpu_now.reg_select == imager_pkg::ADDR_ODD_OFS) begin
      rdata = odd_pixel_offset_ff[pointer];
    end else if (mpu_now.reg_select == imager_pkg::ADDR_EVEN_OFS) begin
      rdata = even_pixel_offset_ff[pointer];
    end else if (mpu_now.reg_select == imager_pkg::ADDR_INPUT_OFS) begin
      rdata = analog_input_offset_ff[pointer];
    end
  end

  // ---------------------------------------------------------------
  // Analog control outputs
  // ---------------------------------------------------------------
  imager_pkg::clamp_t clamp_mode;

  assign clamp_mode = imager_pkg::clamp_t'(mode_config_two_ff[imager_pkg::CFG2_CLAMP_LSB +: 2]);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sampler_enable_out <= 1'b0;
      mono_mode_out <= 1'b0;
      mono_channel_out <= imager_pkg::COLOUR_RED;
      span_4v_out <= 1'b0;
      span_2v_out <= 1'b0;
      span_ext_out <= 1'b0;
    end else begin
      sampler_enable_out <= mode_config_two_ff[imager_pkg::CFG2_SAMPLER];
      mono_mode_out <= mode_config_two_ff[imager_pkg::CFG2_MONO];
      mono_channel_out <= mono_channel_ff;
      span_4v_out <= mode_config_two_ff[imager_pkg::CFG2_SPAN_4V];
      span_2v_out <= mode_config_two_ff[imager_pkg::CFG2_SPAN_2V];
      span_ext_out <= mode_config_two_ff[imager_pkg::CFG2_SPAN_EXT];
    end
  end

  always_ff @(posedge clk_in) begin
    for (int c = 0; c < imager_pkg::COLOURS; c++) begin
      analog_gain_out[c*imager_pkg::AGAIN_W +: imager_pkg::AGAIN_W] <= analog_gain_setting_ff[c];
      input_offset_out[c*imager_pkg::REG_W +: imager_pkg::REG_W] <= analog_input_offset_ff[c];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      input_clamp_switch_out <= 1'b0;
    end else begin
      case (clamp_mode)
        imager_pkg::CLAMP_LINE: begin
          input_clamp_switch_out <= pix_now.first_sample_clock && !pix_now.line_start;
        end
        imager_pkg::CLAMP_PIXEL: begin
          input_clamp_switch_out <= pix_now.first_sample_clock;
        end
        default: begin
          input_clamp_switch_out <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Channel and parity sequencing
  // ---------------------------------------------------------------
  imager_pkg::seq_t seq_ff;
  logic odd_ff;
  logic [1:0] colour_now;
  logic seq_last;

  always_comb begin
    case (seq_ff)
      imager_pkg::SEQ_GREEN: colour_now = imager_pkg::COLOUR_GREEN;
      imager_pkg::SEQ_BLUE: colour_now = imager_pkg::COLOUR_BLUE;
      default: colour_now = imager_pkg::COLOUR_RED;
    endcase
    if (mode_config_two_ff[imager_pkg::CFG2_MONO]) begin
      colour_now = mono_channel_ff;
    end
  end

  assign seq_last = mode_config_two_ff[imager_pkg::CFG2_MONO] || seq_ff == imager_pkg::SEQ_BLUE;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      seq_ff <= imager_pkg::SEQ_RED;
      odd_ff <= 1'b0;
    end else if (conv_rise) begin
      if (!pix_now.line_start) begin
        seq_ff <= imager_pkg::SEQ_RED;
        odd_ff <= 1'b0;
      end else begin
        case (seq_ff)
          imager_pkg::SEQ_RED: seq_ff <= imager_pkg::SEQ_GREEN;
          imager_pkg::SEQ_GREEN: seq_ff <= imager_pkg::SEQ_BLUE;
          default: seq_ff <= imager_pkg::SEQ_RED;
        endcase
        if (mode_config_two_ff[imager_pkg::CFG2_MONO]) begin
          seq_ff <= imager_pkg::SEQ_RED;
        end
        // Parity flips once per full pixel set
        if (seq_last) begin
          odd_ff <= !odd_ff;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      channel_sel_out <= imager_pkg::COLOUR_RED;
    end else begin
      channel_sel_out <= colour_now;
    end
  end

  // ---------------------------------------------------------------
  // Correction datapath
  // ---------------------------------------------------------------
  logic [imager_pkg::REG_W-1:0] parity_ofs;
  logic [imager_pkg::SUM_W-1:0] oe_sum;
  logic [imager_pkg::PIX_W-1:0] oe_sat;
  logic [imager_pkg::GAIN_W-1:0] gain_word;
  logic [imager_pkg::OFS_W-1:0] ofs_word;
  logic sub_on;

  assign parity_ofs = odd_ff ? odd_pixel_offset_ff[colour_now] : even_pixel_offset_ff[colour_now];
  assign oe_sum = {2'b00, adc_code_in} + {{(imager_pkg::SUM_W-imager_pkg::REG_W){parity_ofs[imager_pkg::REG_W-1]}},
                                          parity_ofs};

  always_comb begin
    if (oe_sum[imager_pkg::SUM_W-1]) begin
      oe_sat = imager_pkg::PIX_ZERO;
    end else if (oe_sum[imager_pkg::PIX_W]) begin
      oe_sat = imager_pkg::PIX_MAX;
    end else begin
      oe_sat = oe_sum[imager_pkg::PIX_W-1:0];
    end
  end

  always_comb begin
    gain_word = pix_now.gain;
    ofs_word = {2'b00, pix_now.offset};
    sub_on = 1'b1;
    if (config_ff[imager_pkg::CFG_DIST_A]) begin
      gain_word = {pix_now.gain[imager_pkg::GAIN_W-1:2], 2'b00};
      ofs_word = {pix_now.gain[1:0], pix_now.offset};
    end else if (config_ff[imager_pkg::CFG_DIST_B]) begin
      gain_word = {pix_now.gain[imager_pkg::GAIN_W-1:1], 1'b0};
      ofs_word = {1'b0, pix_now.gain[0], pix_now.offset};
    end else if (!config_ff[imager_pkg::CFG_DIST_C]) begin
      ofs_word = '0;
      sub_on = 1'b0;
    end
  end

  logic [imager_pkg::PIX_W-1:0] corr_ff;
  logic [imager_pkg::GAIN_W-1:0] gain_lat_ff;
  logic [imager_pkg::OFS_W-1:0] ofs_lat_ff;
  logic sub_on_ff;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      corr_ff <= imager_pkg::PIX_RESET;
      gain_lat_ff <= '0;
      ofs_lat_ff <= '0;
      sub_on_ff <= 1'b0;
    end else if (conv_rise) begin
      corr_ff <= oe_sat;
      gain_lat_ff <= gain_word;
      ofs_lat_ff <= ofs_word;
      sub_on_ff <= sub_on;
    end
  end

  logic [imager_pkg::DIFF_W-1:0] diff;
  logic [imager_pkg::PIX_W-1:0] diff_ff;
  logic [imager_pkg::GAIN_W-1:0] gain_pipe_ff;

  assign diff = {1'b0, corr_ff} - {{(imager_pkg::DIFF_W-imager_pkg::OFS_W){1'b0}}, ofs_lat_ff};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      diff_ff <= imager_pkg::PIX_RESET;
      gain_pipe_ff <= '0;
    end else if (conv_rise) begin
      gain_pipe_ff <= gain_lat_ff;
      if (!sub_on_ff) begin
        diff_ff <= corr_ff;
      end else if (diff[imager_pkg::DIFF_W-1]) begin
        diff_ff <= imager_pkg::PIX_ZERO;
      end else begin
        diff_ff <= diff[imager_pkg::PIX_W-1:0];
      end
    end
  end

  logic [imager_pkg::SCALE_W-1:0] scale;
  logic [imager_pkg::PROD_W-1:0] prod;
  logic [imager_pkg::SUM_W-1:0] mul_sum;
  logic [imager_pkg::PIX_W-1:0] pixel_ff;

  // Zero word gives unity
  // Scale adds a fraction of the difference, so gain never falls below one
  assign scale = config_ff[imager_pkg::CFG_SCALE_LSB +: imager_pkg::SCALE_W];
  assign prod = imager_pkg::PROD_W'(diff_ff) * imager_pkg::PROD_W'(gain_pipe_ff) * imager_pkg::PROD_W'(scale);
  assign mul_sum = {2'b00, diff_ff} + {1'b0, prod[imager_pkg::PROD_W-1:imager_pkg::MUL_SHIFT]};

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pixel_ff <= imager_pkg::PIX_RESET;
    end else if (conv_rise) begin
      if (scale == '0) begin
        pixel_ff <= diff_ff;
      end else if (mul_sum[imager_pkg::SUM_W-1:imager_pkg::PIX_W] != '0) begin
        pixel_ff <= imager_pkg::PIX_MAX;
      end else begin
        pixel_ff <= mul_sum[imager_pkg::PIX_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Data bus drive
  // ---------------------------------------------------------------
  // Register port on read strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      data_bus_out <= imager_pkg::PIX_RESET;
      data_bus_oe_out <= 1'b0;
    end else if (read_active) begin
      data_bus_out <= {{(imager_pkg::PIX_W-imager_pkg::REG_W){1'b0}}, rdata};
      data_bus_oe_out <= 1'b1;
    end else if (write_active) begin
      data_bus_out <= pixel_ff;
      data_bus_oe_out <= 1'b0;
    end else begin
      data_bus_out <= pixel_ff;
      data_bus_oe_out <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// [tb/imager_ctrl_asserts.sv]
// Port-level assertions for the imager control block
`timescale 1ns/100ps
`default_nettype none
module imager_ctrl_asserts (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic read_strobe_n_in,
  input wire logic converter_clock_in,
  input wire logic first_sample_clock_in,
  input wire logic [11:0] data_bus_out,
  input wire logic data_bus_oe_out,
  input wire logic mono_mode_out,
  input wire logic [1:0] mono_channel_out,
  input wire logic input_clamp_switch_out,
  input wire logic [1:0] channel_sel_out,
  input wire logic [11:0] analog_gain_out,
  input wire logic [23:0] input_offset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Eight quiet cycles outlast the pin filter plus the output flop
  sequence quiet_conv;
    !converter_clock_in [*8];
  endsequence
  sequence quiet_read;
    read_strobe_n_in [*8];
  endsequence
  a_release_idle: assert property ($fell(reset_in) |-> !data_bus_oe_out && data_bus_out == 12'h000)
    else $error("outputs not idle after reset");
  a_oe_idle: assert property (chip_select_n_in [*8] |-> data_bus_oe_out)
    else $error("bus not driven while deselected");
  a_clamp_quiet: assert property (!first_sample_clock_in [*6] |-> !input_clamp_switch_out)
    else $error("clamp on without sample clock");
  a_cfg_hold: assert property (write_strobe_n_in [*8] |->
    $stable({mono_mode_out, analog_gain_out, input_offset_out}))
    else $error("register changed without write");
  a_pix_hold: assert property (quiet_conv and quiet_read |-> $stable(data_bus_out))
    else $error("pixel changed without converter edge");
  // A single-channel write moves the channel without a converter edge
  a_chan_hold: assert property (quiet_conv and write_strobe_n_in [*8] |-> $stable(channel_sel_out))
    else $error("sequencer moved without converter edge");
  a_chan_legal: assert property (channel_sel_out != 2'h3)
    else $error("sequencer on unused channel");
  a_mono_legal: assert property (mono_channel_out != 2'h3)
    else $error("single channel on reserved colour");
endmodule
bind imager_ctrl_regs imager_ctrl_asserts u_chk (.clk_in, .reset_in, .chip_select_n_in, .write_strobe_n_in,
  .read_strobe_n_in, .converter_clock_in, .first_sample_clock_in, .data_bus_out, .data_bus_oe_out,
  .mono_mode_out, .mono_channel_out, .input_clamp_switch_out, .channel_sel_out, .analog_gain_out, .input_offset_out);
`default_nettype wire

// [tb/scan_ctrl_model.sv]
// Scanner controller model driving the pixel-rate pins
`timescale 1ns/100ps
`default_nettype none
module scan_ctrl_model (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic [11:0] code_in,
  output logic conv_out = 1'b0,
  output logic [11:0] code_out = 12'h000,
  output logic [11:0] gain_out = 12'h000,
  output logic [7:0] ofs_out = 8'h00
);
  logic [2:0] cnt = 3'h0;
  // Clock stands low between runs; four cycles each phase
  always @(posedge clk_in) begin
    cnt <= run_in ? cnt + 3'h1 : 3'h0;
    conv_out <= run_in & cnt[2];
  end
  // Buses change only mid low phase
  always @(posedge clk_in) begin
    if (!run_in || cnt == 3'h1) {code_out, gain_out, ofs_out} <= {code_in, 12'h800, 8'h40};
  end
endmodule
`default_nettype wire

// [tb/tb_imager_ctrl_regs_pixel_correction.sv]
// Self-checking bench for the imager control block
`timescale 1ns/100ps
`default_nettype none
module tb_imager_ctrl_regs_pixel_correction;
  typedef struct packed {logic [7:0] cfg; logic [2:0] sel; logic [7:0] wd; logic [7:0] rd;} row_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic chip_select_n_in = 1'b1;
  logic write_strobe_n_in = 1'b1;
  logic read_strobe_n_in = 1'b1;
  logic line_start_in = 1'b1;
  logic first_sample_clock_in = 1'b0;
  logic run = 1'b0;
  logic [2:0] reg_select_in = 3'h0;
  logic [11:0] data_bus_in = 12'h000;
  logic [11:0] data_bus_out, adc_code_in, gain_bus_in, analog_gain_out;
  logic [7:0] offset_bus_in, rdv;
  logic [23:0] input_offset_out;
  logic [1:0] mono_channel_out, channel_sel_out;
  logic data_bus_oe_out, converter_clock_in, sampler_enable_out, mono_mode_out;
  logic span_4v_out, span_2v_out, span_ext_out, input_clamp_switch_out;
  int n_fail = 0;
  int cmp_count = 0;
  row_t rows [7] = '{'{8'h00, 3'h5, 8'hA5, 8'hA5}, '{8'h40, 3'h2, 8'hF7, 8'h07}, '{8'h80, 3'h3, 8'h80, 8'h80},
    '{8'h00, 3'h4, 8'h7F, 8'h7F}, '{8'hC0, 3'h5, 8'h11, 8'h00}, '{8'h00, 3'h6, 8'h33, 8'h00},
    '{8'h80, 3'h1, 8'h8D, 8'h8D}};
  always #10 clk_in = ~clk_in;
  imager_ctrl_regs u_dut (.clk_in, .reset_in, .chip_select_n_in, .write_strobe_n_in, .read_strobe_n_in,
    .reg_select_in, .data_bus_in, .data_bus_out, .data_bus_oe_out, .converter_clock_in, .line_start_in,
    .first_sample_clock_in, .gain_bus_in, .offset_bus_in, .adc_code_in, .sampler_enable_out, .mono_mode_out,
    .mono_channel_out, .span_4v_out, .span_2v_out, .span_ext_out, .input_clamp_switch_out, .channel_sel_out,
    .analog_gain_out, .input_offset_out);
  scan_ctrl_model u_scan (.clk_in, .run_in(run), .code_in(12'h100), .conv_out(converter_clock_in),
    .code_out(adc_code_in), .gain_out(gain_bus_in), .ofs_out(offset_bus_in));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobes held well past the pin filter; read data taken at the release edge
  task automatic bus(input logic [2:0] s, input logic [7:0] d, input logic rd);
    @(posedge clk_in);
    reg_select_in <= s;
    data_bus_in <= {4'h0, d};
    chip_select_n_in <= 1'b0;
    write_strobe_n_in <= rd;
    read_strobe_n_in <= ~rd;
    repeat (7) @(posedge clk_in);
    rdv = data_bus_out[7:0];
    chip_select_n_in <= 1'b1;
    write_strobe_n_in <= 1'b1;
    read_strobe_n_in <= 1'b1;
    repeat (7) @(posedge clk_in);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(data_bus_oe_out, 1'b1);
    foreach (rows[i]) begin
      bus(3'h0, rows[i].cfg, 1'b0);
      bus(rows[i].sel, rows[i].wd, 1'b0);
      bus(rows[i].sel, 8'h00, 1'b1);
      chk(rdv, rows[i].rd);
    end
    chk({mono_channel_out, sampler_enable_out, mono_mode_out,
         span_4v_out, span_2v_out, span_ext_out}, 7'h56);
    chk(analog_gain_out, 12'h070);
    chk(input_offset_out, 24'h0000A5);
    first_sample_clock_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(input_clamp_switch_out, 1'b0);
    bus(3'h1, 8'h4D, 1'b0);
    chk(input_clamp_switch_out, 1'b1);
    bus(3'h1, 8'h0D, 1'b0);
    chk(input_clamp_switch_out, 1'b0);
    line_start_in <= 1'b0;
    run <= 1'b1;
    repeat (60) @(posedge clk_in);
    chk(input_clamp_switch_out, 1'b1);
    chk({channel_sel_out, data_bus_out}, 14'h017F);
    bus(3'h1, 8'h0F, 1'b0);
    chk({mono_mode_out, channel_sel_out}, 3'h6);
    bus(3'h1, 8'h0D, 1'b0);
    bus(3'h0, 8'h21, 1'b0);
    // Line start rises one clock after a converter edge, so that edge still resets to red
    repeat (3) @(posedge converter_clock_in);
    @(posedge clk_in);
    line_start_in <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      @(posedge converter_clock_in);
      repeat (7) @(posedge clk_in);
      chk({channel_sel_out, data_bus_out}, {2'((k + 1) % 3), k < 3 ? 12'h166 : 12'h0D8});
    end
    reset_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({analog_gain_out, data_bus_out}, 24'h000000);
    chk(input_offset_out, 24'h000000);
    conclude;
  end
endmodule
`default_nettype wire
